// *** testbench/hufc_link_props.sv ***
// Timing checks on the serial wires between the two ends
`timescale 1ns/1ps
module hufc_link_props #(
  parameter int BIT_MIN = 180,
  parameter int LOW_MAX = 2200,
  parameter int IDLE_MIN = 2600
) (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic dev_txd,
  input wire logic host_txd,
  input wire logic dev_rts_b,
  input wire logic host_rts_b,
  input wire logic transfer_mode_select_pin
);
  logic [1:0] prv;
  logic [1:0] ln;
  logic [15:0] run [2];
  assign ln = {host_txd, dev_txd};
  // Length of the level just ended; saturates so a long idle never wraps
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prv <= 2'h3;
      run <= '{16'hffff, 16'hffff};
    end else begin
      prv <= ln;
      for (int i = 0; i < 2; i++) begin
        run[i] <= (ln[i] != prv[i]) ? 16'h0001 : run[i] + 16'(run[i] != 16'hffff);
      end
    end
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  property p_dbit; (dev_txd != prv[0]) |-> run[0] >= 16'(BIT_MIN); endproperty
  a_dbit: assert property (p_dbit) else $error("device bit short");
  property p_hbit; (host_txd != prv[1]) |-> run[1] >= 16'(BIT_MIN); endproperty
  a_hbit: assert property (p_hbit) else $error("host bit short");
  property p_dlow; (!dev_txd && !prv[0]) |-> run[0] <= 16'(LOW_MAX); endproperty
  a_dlow: assert property (p_dlow) else $error("device stop missing");
  property p_hlow; (!host_txd && !prv[1]) |-> run[1] <= 16'(LOW_MAX); endproperty
  a_hlow: assert property (p_hlow) else $error("host stop missing");
  property p_dgate; (!dev_txd && prv[0] && run[0] >= 16'(IDLE_MIN)) |-> !$past(host_rts_b, 1);
  endproperty
  a_dgate: assert property (p_dgate) else $error("device sent against cts");
  property p_hgate; (!host_txd && prv[1] && run[1] >= 16'(IDLE_MIN)) |-> !$past(dev_rts_b, 1);
  endproperty
  a_hgate: assert property (p_hgate) else $error("host sent against rts");
  property p_dstart; $fell(dev_txd) |=> !dev_txd [*8]; endproperty
  a_dstart: assert property (p_dstart) else $error("device start short");
  property p_hstart; $fell(host_txd) |=> !host_txd [*8]; endproperty
  a_hstart: assert property (p_hstart) else $error("host start short");
endmodule // hufc_link_props

// *** testbench/tb_top.sv ***
// Bench joining device end and host end over the serial link
`timescale 1ns/1ps
module tb_top;
  localparam logic [15:0] DIV = 16'h001b;
  logic clk_sys_in = 1'b0, rst_b_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0, link_up_in = 1'b1;
  logic pwrite_in = 1'b0, pready_out, pslverr_out, e, tx_ready_out, rx_valid_out;
  logic flow_en_in = 1'b0, mode_cmd_in = 1'b0, tx_valid_in = 1'b0, rx_ready_in = 1'b0;
  logic [7:0] paddr_in = 8'h00, tx_data_in = 8'h00, rx_data_out;
  logic [31:0] pwdata_in = 32'h0, prdata_out, q, r, seed = 32'h48;
  logic [1:0] len_in = 2'h3, par_in = 2'h0, stop_in = 2'h0, rx_err_out;
  logic [5:0] cfg [4] = '{6'h04, 6'h19, 6'h22, 6'h38};
  int err_total = 0, n_tests = 0;
  hufc_link_if link ();
  hufc_dev #(.DIV_RESET(DIV)) i_hufc_dev (.clk_sys_in, .rst_b_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
    .link_up_in, .link);
  hufc_host i_hufc_host (.clk_sys_in, .rst_b_in, .div_in(DIV), .len_in, .par_in, .stop_in,
    .flow_en_in, .mode_cmd_in, .tx_valid_in, .tx_data_in, .tx_ready_out, .rx_valid_out,
    .rx_data_out, .rx_err_out, .rx_ready_in, .link);
  hufc_link_props i_hufc_link_props (.clk_sys_in, .rst_b_in, .dev_txd(link.dev_txd),
    .host_txd(link.host_txd), .dev_rts_b(link.dev_rts_b), .host_rts_b(link.host_rts_b),
    .transfer_mode_select_pin(link.transfer_mode_select_pin));
  always #2.5 clk_sys_in = ~clk_sys_in;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] msk(input logic [7:0] d, input logic [1:0] l);
    return {24'h0, d & (8'hff >> (2'h3 - l))};
  endfunction
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    do @(posedge clk_sys_in); while (pready_out !== 1'b1);
    q = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task automatic dget(input logic [7:0] x, input logic [1:0] l);
    do apb(1'b0, hufc_pkg::REG_STAT, 32'h0); while (q[hufc_pkg::ST_RXV] !== 1'b1);
    apb(1'b0, hufc_pkg::REG_RXD, 32'h0);
    chk("dev rx", msk(x, l), q);
  endtask
  // Ready only while waiting, so a word cannot be popped before it is looked at
  task automatic hget(input logic [7:0] x);
    rx_ready_in <= 1'b1;
    do @(posedge clk_sys_in); while (rx_valid_out !== 1'b1);
    chk("host rx", msk(x, len_in), {22'h0, rx_err_out, rx_data_out});
    rx_ready_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task automatic hsend(input logic [7:0] d);
    tx_valid_in <= 1'b1;
    tx_data_in <= d;
    do @(posedge clk_sys_in); while (tx_ready_out !== 1'b1);
    tx_valid_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    @(posedge clk_sys_in);
    apb(1'b0, hufc_pkg::REG_CTRL, 32'h0);
    chk("ctrl", 32'h3, q);
    apb(1'b0, hufc_pkg::REG_BAUD, 32'h0);
    chk("baud", {16'h0, DIV}, q);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h1, {31'h0, e});
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      {len_in, par_in, stop_in} <= cfg[i];
      mode_cmd_in <= r[16];
      link_up_in <= r[17];
      apb(1'b1, hufc_pkg::REG_CTRL, {26'h0, cfg[i][1:0], cfg[i][3:2], cfg[i][5:4]});
      hsend(r[7:0]);
      apb(1'b1, hufc_pkg::REG_TXD, {24'h0, r[15:8]});
      dget(r[7:0], cfg[i][5:4]);
      hget(r[15:8]);
      apb(1'b0, hufc_pkg::REG_STAT, 32'h0);
      chk("mode", {31'h0, r[16] & r[17]}, {31'h0, q[hufc_pkg::ST_MODE]});
      $display("format test %0d done", i);
    end
    {len_in, par_in, stop_in} <= 6'h30;
    flow_en_in <= 1'b1;
    apb(1'b1, hufc_pkg::REG_CTRL, 32'h43);
    hsend(8'h00);
    hsend(8'hff);
    hsend(8'ha5);
    // Room for three frames, so an ignored RTS would overrun the buffer
    repeat (8000) @(posedge clk_sys_in);
    dget(8'h00, 2'h3);
    dget(8'hff, 2'h3);
    dget(8'ha5, 2'h3);
    apb(1'b0, hufc_pkg::REG_EVT, 32'h0);
    chk("overrun", 32'h0, {31'h0, q[hufc_pkg::EV_OVERRUN]});
    apb(1'b1, hufc_pkg::REG_EVT, 32'h3ff);
    apb(1'b0, hufc_pkg::REG_EVT, 32'h0);
    chk("evt clear", 32'h0, q);
    $display("receive flow test done");
    rx_ready_in <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, hufc_pkg::REG_TXD, {24'h0, 8'h3c + 8'(i)});
      chk("txd taken", 32'h0, {31'h0, e});
    end
    repeat (8000) @(posedge clk_sys_in);
    for (int i = 0; i < 3; i++) begin
      hget(8'h3c + 8'(i));
    end
    $display("transmit flow test done");
    complete_run();
  end
  initial begin
    // Fourteen frames of up to 2400 cycles plus two 8000-cycle waits, doubled for slack
    repeat (100000) @(posedge clk_sys_in);
    err_total++;
    complete_run();
  end
endmodule // tb_top

// *** verilog/hufc_dev.sv ***
// Device end: word buffer, baud divider and APB register slave
// What this block does
// - One full-duplex channel, separate transmit and receive
// - Receiver deserializes, transmitter serializes words
// - Ten separately reported event causes
// - Data only on serial lines; others handshake
// - RTS and CTS are active low
// - Host stops sending while device RTS deasserted
// - Receive overflow must not corrupt device state
// - Rates 1200 to 921600, default 115200
// - Flow control selectable: RTS/CTS or none
// - Parity none, odd or even; generated, checked
// - Stop bits one, one and half, two
// - Five to eight data bits per frame
// - Mode pin high command, low throughput, when linked
`timescale 1ns/1ps

module hufc_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic in_valid_in,
  input wire logic [W-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [W-1:0] out_data_out,
  input wire logic out_ready_in,
  output logic [$clog2(DEPTH+1)-1:0] level_out
);
  localparam int CW = $clog2(DEPTH + 1);
  logic [W-1:0] mem [DEPTH];
  logic [CW-1:0] next_cnt;
  logic push;
  logic pop;
  if (DEPTH < 2) begin : g_chk
    $error("hufc_fifo needs at least two entries");
  end
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  assign next_cnt = CW'(level_out + CW'(push) - CW'(pop));
  assign out_data_out = mem[0];
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      level_out <= '0;
      in_ready_out <= 1'b1;
      out_valid_out <= 1'b0;
    end else begin
      level_out <= next_cnt;
      in_ready_out <= next_cnt < CW'(DEPTH);
      out_valid_out <= next_cnt != '0;
    end
  end
  // Head always sits in entry 0, so the reader sees a flop
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        mem[i] <= '0;
      end else if (pop) begin
        if (CW'(i + 1) < level_out) begin
          mem[i] <= mem[(i + 1) % DEPTH];
        end else if (push && CW'(i + 1) == level_out) begin
          mem[i] <= in_data_in;
        end
      end else if (push && CW'(i) == level_out) begin
        mem[i] <= in_data_in;
      end
    end
  end
endmodule // hufc_fifo

module hufc_dev #(
  parameter logic [15:0] DIV_RESET = hufc_pkg::DIV_DEF,
  parameter int DEPTH = hufc_pkg::FIFO_DEPTH
) (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic link_up_in,
  hufc_link_if.dev link
);
  localparam int CW = $clog2(DEPTH + 1);
  logic [6:0] ctrl;
  logic [15:0] baud;
  logic [15:0] dcnt;
  logic tick;
  logic [hufc_pkg::EV_W-1:0] evt;
  logic [hufc_pkg::EV_W-1:0] ev_set;
  logic [hufc_pkg::EV_W-1:0] ev_clr;
  logic [1:0] len, par, stp;
  logic flow, acc, wr, mode, cts_prev, rts_prev, mode_prev, busy_prev;
  logic txf_rdy, txf_v, tx_rdy, busy, rxv, perr, ferr, brk, rxf_rdy, rxf_v, rx_pop;
  logic [7:0] txf_d, rxd8;
  logic [9:0] rxf_d;
  logic [CW-1:0] txf_lvl, rxf_lvl;
  logic [31:0] next_rdata;
  logic next_err;
  if (DIV_RESET < hufc_pkg::DIV_MIN || DIV_RESET > hufc_pkg::DIV_MAX) begin : g_chk
    $error("hufc_dev divisor outside supported rates");
  end
  assign len = ctrl[hufc_pkg::CTRL_LEN_LSB +: 2];
  assign par = ctrl[hufc_pkg::CTRL_PAR_LSB +: 2];
  assign stp = ctrl[hufc_pkg::CTRL_STOP_LSB +: 2];
  assign flow = ctrl[hufc_pkg::CTRL_FLOW_BIT];
  assign acc = psel_in && penable_in && pready_out;
  assign wr = acc && pwrite_in;
  assign rx_pop = acc && !pwrite_in && paddr_in == hufc_pkg::REG_RXD;

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dcnt <= '0;
      tick <= 1'b0;
    end else begin
      tick <= dcnt >= 16'(baud - 16'h0001);
      dcnt <= (dcnt >= 16'(baud - 16'h0001)) ? 16'h0000 : 16'(dcnt + 16'h0001);
    end
  end

  hufc_fifo #(.W(8), .DEPTH(DEPTH)) u_txf (
    .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .in_valid_in(wr && paddr_in == hufc_pkg::REG_TXD), .in_data_in(pwdata_in[7:0]),
    .in_ready_out(txf_rdy), .out_valid_out(txf_v), .out_data_out(txf_d),
    .out_ready_in(tx_rdy), .level_out(txf_lvl));
  hufc_tx u_tx (
    .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .tick_in(tick),
    .len_in(len), .par_in(par), .stop_in(stp),
    .send_ok_in(!flow || !link.host_rts_b), .in_valid_in(txf_v), .in_data_in(txf_d),
    .in_ready_out(tx_rdy), .txd_out(link.dev_txd), .busy_out(busy));
  hufc_rx u_rx (
    .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .tick_in(tick),
    .len_in(len), .par_in(par), .rxd_in(link.host_txd),
    .valid_out(rxv), .data_out(rxd8), .perr_out(perr), .ferr_out(ferr), .brk_out(brk));
  hufc_fifo #(.W(10), .DEPTH(DEPTH)) u_rxf (
    .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .in_valid_in(rxv), .in_data_in({ferr, perr, rxd8}),
    .in_ready_out(rxf_rdy), .out_valid_out(rxf_v), .out_data_out(rxf_d),
    .out_ready_in(rx_pop), .level_out(rxf_lvl));

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      link.dev_rts_b <= 1'b1;
    end else begin
      link.dev_rts_b <= flow && rxf_lvl >= CW'(DEPTH - 1);
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mode <= 1'b0;
    end else begin
      mode <= link_up_in && link.transfer_mode_select_pin;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl <= hufc_pkg::CTRL_RST;
      baud <= DIV_RESET;
    end else if (wr && paddr_in == hufc_pkg::REG_CTRL) begin
      ctrl <= pwdata_in[6:0];
    end else if (wr && paddr_in == hufc_pkg::REG_BAUD && pwdata_in[15:0] != 16'h0000) begin
      baud <= pwdata_in[15:0];
    end
  end

  always_comb begin
    ev_set = '0;
    ev_set[hufc_pkg::EV_RXDONE] = rxv && rxf_rdy;
    ev_set[hufc_pkg::EV_TXTAKE] = txf_v && tx_rdy;
    ev_set[hufc_pkg::EV_TXDONE] = busy_prev && !busy;
    ev_set[hufc_pkg::EV_OVERRUN] = rxv && !rxf_rdy;
    ev_set[hufc_pkg::EV_PARITY] = rxv && perr;
    ev_set[hufc_pkg::EV_FRAME] = rxv && ferr;
    ev_set[hufc_pkg::EV_BREAK] = rxv && brk;
    ev_set[hufc_pkg::EV_CTS] = cts_prev != link.host_rts_b;
    ev_set[hufc_pkg::EV_RTS] = rts_prev != link.dev_rts_b;
    ev_set[hufc_pkg::EV_MODE] = mode_prev != mode;
    ev_clr = (wr && paddr_in == hufc_pkg::REG_EVT) ? pwdata_in[hufc_pkg::EV_W-1:0] : '0;
  end

  // Set beats a simultaneous clear so no event slips through
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      evt <= '0;
      cts_prev <= 1'b1;
      rts_prev <= 1'b1;
      mode_prev <= 1'b0;
      busy_prev <= 1'b0;
    end else begin
      evt <= (evt & ~ev_clr) | ev_set;
      cts_prev <= link.host_rts_b;
      rts_prev <= link.dev_rts_b;
      mode_prev <= mode;
      busy_prev <= busy;
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err = 1'b0;
    case (paddr_in)
      hufc_pkg::REG_CTRL: next_rdata[6:0] = ctrl;
      hufc_pkg::REG_BAUD: next_rdata[15:0] = baud;
      hufc_pkg::REG_STAT: begin
        next_rdata[hufc_pkg::ST_RXV] = rxf_v;
        next_rdata[hufc_pkg::ST_TXR] = txf_rdy;
        next_rdata[hufc_pkg::ST_RTS] = link.dev_rts_b;
        next_rdata[hufc_pkg::ST_CTS] = link.host_rts_b;
        next_rdata[hufc_pkg::ST_MODE] = mode;
        next_rdata[hufc_pkg::ST_BUSY] = busy || txf_v;
      end
      hufc_pkg::REG_EVT: next_rdata[hufc_pkg::EV_W-1:0] = evt;
      hufc_pkg::REG_TXD: next_err = pwrite_in && !txf_rdy;
      hufc_pkg::REG_RXD: next_rdata[9:0] = rxf_v ? rxf_d : 10'h000;
      default: next_err = 1'b1;
    endcase
  end

  // One wait state; answer registered
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pready_out <= 1'b0;
      prdata_out <= '0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= psel_in && penable_in && !pready_out;
      if (psel_in && penable_in && !pready_out) begin
        prdata_out <= pwrite_in ? 32'h0000_0000 : next_rdata;
        pslverr_out <= next_err;
      end else begin
        pslverr_out <= 1'b0;
      end
    end
  end
endmodule // hufc_dev

// *** verilog/hufc_host.sv ***
// Host end, plus the transmit and receive engines that both ends share
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module hufc_host #(
  parameter int DEPTH = hufc_pkg::FIFO_DEPTH
) (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic [15:0] div_in,
  input wire logic [1:0] len_in,
  input wire logic [1:0] par_in,
  input wire logic [1:0] stop_in,
  input wire logic flow_en_in,
  input wire logic mode_cmd_in,
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_data_in,
  output logic tx_ready_out,
  output logic rx_valid_out,
  output logic [7:0] rx_data_out,
  output logic [1:0] rx_err_out,
  input wire logic rx_ready_in,
  hufc_link_if.host link
);
  localparam int CW = $clog2(DEPTH + 1);
  logic [15:0] dcnt;
  logic tick, txf_v, tx_rdy, rxv, perr, ferr, rxf_rdy;
  logic [7:0] txf_d, rxd8;
  logic [CW-1:0] rxf_lvl;
  logic [9:0] rxf_d;
  assign rx_data_out = rxf_d[7:0];
  assign rx_err_out = rxf_d[9:8];

  // Divisor of zero is treated as one
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dcnt <= '0;
      tick <= 1'b0;
    end else begin
      tick <= dcnt >= 16'(div_in - 16'h0001) || div_in == 16'h0000;
      dcnt <= (dcnt >= 16'(div_in - 16'h0001)) ? 16'h0000 : 16'(dcnt + 16'h0001);
    end
  end

  hufc_fifo #(.W(8), .DEPTH(DEPTH)) u_txf (
    .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .in_valid_in(tx_valid_in), .in_data_in(tx_data_in),
    .in_ready_out(tx_ready_out), .out_valid_out(txf_v), .out_data_out(txf_d),
    .out_ready_in(tx_rdy), .level_out());
  hufc_tx u_tx (
    .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .tick_in(tick),
    .len_in(len_in), .par_in(par_in), .stop_in(stop_in),
    .send_ok_in(!flow_en_in || !link.dev_rts_b), .in_valid_in(txf_v), .in_data_in(txf_d),
    .in_ready_out(tx_rdy), .txd_out(link.host_txd), .busy_out());
  hufc_rx u_rx (
    .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .tick_in(tick),
    .len_in(len_in), .par_in(par_in), .rxd_in(link.dev_txd),
    .valid_out(rxv), .data_out(rxd8), .perr_out(perr), .ferr_out(ferr), .brk_out());
  hufc_fifo #(.W(10), .DEPTH(DEPTH)) u_rxf (
    .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .in_valid_in(rxv), .in_data_in({ferr, perr, rxd8}),
    .in_ready_out(rxf_rdy), .out_valid_out(rx_valid_out), .out_data_out(rxf_d),
    .out_ready_in(rx_ready_in), .level_out(rxf_lvl));

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      link.host_rts_b <= 1'b1;
      link.transfer_mode_select_pin <= 1'b0;
    end else begin
      link.host_rts_b <= flow_en_in && rxf_lvl >= CW'(DEPTH - 1);
      link.transfer_mode_select_pin <= mode_cmd_in;
    end
  end
endmodule // hufc_host

module hufc_tx (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic tick_in,
  input wire logic [1:0] len_in,
  input wire logic [1:0] par_in,
  input wire logic [1:0] stop_in,
  input wire logic send_ok_in,
  input wire logic in_valid_in,
  input wire logic [7:0] in_data_in,
  output logic in_ready_out,
  output logic txd_out,
  output logic busy_out
);
  hufc_pkg::hufc_st_t st;
  logic [4:0] tk;
  logic [4:0] last_tk;
  logic [2:0] bitn;
  logic [7:0] sh;
  logic pbit;
  logic bit_end;
  assign in_ready_out = (st == hufc_pkg::HUFC_IDLE) && send_ok_in;
  assign busy_out = st != hufc_pkg::HUFC_IDLE;
  assign last_tk = (st != hufc_pkg::HUFC_STOP) ? hufc_pkg::TK_BIT_LAST :
    (stop_in == hufc_pkg::STOP_15) ? hufc_pkg::TK_STOP15_LAST :
    (stop_in == hufc_pkg::STOP_2) ? hufc_pkg::TK_STOP2_LAST : hufc_pkg::TK_STOP1_LAST;
  assign bit_end = tick_in && tk == last_tk;
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st <= hufc_pkg::HUFC_IDLE;
      tk <= '0;
      bitn <= '0;
      sh <= '0;
      pbit <= 1'b0;
      txd_out <= 1'b1;
    end else if (st == hufc_pkg::HUFC_IDLE) begin
      if (in_valid_in && in_ready_out) begin
        st <= hufc_pkg::HUFC_START;
        tk <= '0;
        sh <= in_data_in;
        pbit <= hufc_pkg::hufc_parity(in_data_in, len_in, par_in);
        txd_out <= 1'b0;
      end
    end else if (tick_in) begin
      tk <= bit_end ? 5'h00 : 5'(tk + 5'h01);
      if (bit_end) begin
        case (st)
          hufc_pkg::HUFC_START: begin
            st <= hufc_pkg::HUFC_DATA;
            bitn <= '0;
            txd_out <= sh[0];
          end
          hufc_pkg::HUFC_DATA: begin
            if (bitn == 3'(hufc_pkg::LEN_BASE_LAST + 3'(len_in))) begin
              st <= (par_in == hufc_pkg::PAR_NONE) ? hufc_pkg::HUFC_STOP : hufc_pkg::HUFC_PAR;
              txd_out <= (par_in == hufc_pkg::PAR_NONE) ? 1'b1 : pbit;
            end else begin
              bitn <= 3'(bitn + 3'h1);
              sh <= sh >> 1;
              txd_out <= sh[1];
            end
          end
          hufc_pkg::HUFC_PAR: begin
            st <= hufc_pkg::HUFC_STOP;
            txd_out <= 1'b1;
          end
          default: begin
            st <= hufc_pkg::HUFC_IDLE;
            txd_out <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule // hufc_tx

module hufc_rx (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic tick_in,
  input wire logic [1:0] len_in,
  input wire logic [1:0] par_in,
  input wire logic rxd_in,
  output logic valid_out,
  output logic [7:0] data_out,
  output logic perr_out,
  output logic ferr_out,
  output logic brk_out
);
  hufc_pkg::hufc_st_t st;
  logic [4:0] tk;
  logic [2:0] bitn;
  logic [7:0] sh;
  logic [7:0] word;
  logic pbit;
  assign word = sh >> (hufc_pkg::LEN_8 - len_in);
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st <= hufc_pkg::HUFC_IDLE;
      tk <= '0;
      bitn <= '0;
      sh <= '0;
      pbit <= 1'b0;
      valid_out <= 1'b0;
      data_out <= '0;
      perr_out <= 1'b0;
      ferr_out <= 1'b0;
      brk_out <= 1'b0;
    end else begin
      valid_out <= 1'b0;
      if (tick_in) begin
        tk <= 5'(tk + 5'h01);
        case (st)
          hufc_pkg::HUFC_IDLE: begin
            tk <= '0;
            if (!rxd_in) st <= hufc_pkg::HUFC_START;
          end
          hufc_pkg::HUFC_START: begin
            if (tk == hufc_pkg::TK_HALF_LAST) begin
              tk <= '0;
              bitn <= '0;
              st <= rxd_in ? hufc_pkg::HUFC_IDLE : hufc_pkg::HUFC_DATA;
            end
          end
          hufc_pkg::HUFC_DATA: begin
            if (tk == hufc_pkg::TK_BIT_LAST) begin
              tk <= '0;
              sh <= {rxd_in, sh[7:1]};
              bitn <= 3'(bitn + 3'h1);
              if (bitn == 3'(hufc_pkg::LEN_BASE_LAST + 3'(len_in))) begin
                st <= (par_in == hufc_pkg::PAR_NONE) ? hufc_pkg::HUFC_STOP : hufc_pkg::HUFC_PAR;
              end
            end
          end
          hufc_pkg::HUFC_PAR: begin
            if (tk == hufc_pkg::TK_BIT_LAST) begin
              tk <= '0;
              pbit <= rxd_in;
              st <= hufc_pkg::HUFC_STOP;
            end
          end
          default: begin
            if (tk == hufc_pkg::TK_BIT_LAST) begin
              st <= hufc_pkg::HUFC_IDLE;
              valid_out <= 1'b1;
              data_out <= word;
              perr_out <= par_in != hufc_pkg::PAR_NONE &&
                pbit != hufc_pkg::hufc_parity(word, len_in, par_in);
              ferr_out <= !rxd_in;
              brk_out <= !rxd_in && word == 8'h00;
            end
          end
        endcase
      end
    end
  end
endmodule // hufc_rx

// *** verilog/hufc_link_if.sv ***
// Serial link wires between the device end and the host end
`timescale 1ns/1ps
interface hufc_link_if;
  logic dev_txd;
  logic host_txd;
  logic dev_rts_b;
  logic host_rts_b;
  logic transfer_mode_select_pin;
  modport dev(output dev_txd, output dev_rts_b, input host_txd, input host_rts_b,
    input transfer_mode_select_pin);
  modport host(input dev_txd, input dev_rts_b, output host_txd, output host_rts_b,
    output transfer_mode_select_pin);
endinterface // hufc_link_if

// *** verilog/hufc_pkg.sv ***
// Shared constants, encodings and helpers for the host serial channel
package hufc_pkg;
  localparam int CLK_HZ = 200_000_000;
  localparam int OVS = 8;
  localparam int BAUD_MIN = 1200;
  localparam int BAUD_DEF = 115200;
  localparam int BAUD_MAX = 921600;
  // Divisors of the oversampling tick; default rate errs by under 0.1 percent
  localparam logic [15:0] DIV_DEF = 16'(CLK_HZ / (BAUD_DEF * OVS));
  localparam logic [15:0] DIV_MIN = 16'(CLK_HZ / (BAUD_MAX * OVS));
  localparam logic [15:0] DIV_MAX = 16'(CLK_HZ / (BAUD_MIN * OVS));
  localparam int FIFO_DEPTH = 2;
  // Ticks per bit, last index of each span
  localparam logic [4:0] TK_BIT_LAST = 5'h07;
  localparam logic [4:0] TK_HALF_LAST = 5'h03;
  localparam logic [4:0] TK_STOP1_LAST = 5'h07;
  localparam logic [4:0] TK_STOP15_LAST = 5'h0b;
  localparam logic [4:0] TK_STOP2_LAST = 5'h0f;
  localparam logic [2:0] LEN_BASE_LAST = 3'h4;
  localparam logic [1:0] LEN_8 = 2'h3;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h1;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [1:0] STOP_1 = 2'h0;
  localparam logic [1:0] STOP_15 = 2'h1;
  localparam logic [1:0] STOP_2 = 2'h2;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_BAUD = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_EVT = 8'h0c;
  localparam logic [7:0] REG_TXD = 8'h10;
  localparam logic [7:0] REG_RXD = 8'h14;
  localparam int CTRL_LEN_LSB = 0;
  localparam int CTRL_PAR_LSB = 2;
  localparam int CTRL_STOP_LSB = 4;
  localparam int CTRL_FLOW_BIT = 6;
  localparam logic [6:0] CTRL_RST = 7'h03;
  localparam int ST_RXV = 0;
  localparam int ST_TXR = 1;
  localparam int ST_RTS = 2;
  localparam int ST_CTS = 3;
  localparam int ST_MODE = 4;
  localparam int ST_BUSY = 5;
  localparam int EV_W = 10;
  localparam int EV_RXDONE = 0;
  localparam int EV_TXTAKE = 1;
  localparam int EV_TXDONE = 2;
  localparam int EV_OVERRUN = 3;
  localparam int EV_PARITY = 4;
  localparam int EV_FRAME = 5;
  localparam int EV_BREAK = 6;
  localparam int EV_CTS = 7;
  localparam int EV_RTS = 8;
  localparam int EV_MODE = 9;
  typedef enum logic [2:0] {
    HUFC_IDLE = 3'b000,
    HUFC_START = 3'b001,
    HUFC_DATA = 3'b010,
    HUFC_PAR = 3'b011,
    HUFC_STOP = 3'b100
  } hufc_st_t;

  // Parity over the active data bits only
  function automatic logic hufc_parity(logic [7:0] d, logic [1:0] len, logic [1:0] par);
    logic [7:0] m;
    m = 8'hff >> (LEN_8 - len);
    return (^(d & m)) ^ (par == PAR_ODD);
  endfunction
endpackage
